// [hw/battery_charge_cycle_controller.sv]
// charge cycle sequencing, thermistor qualification, status and event pulses
`timescale 1ns/10ps
// What this block does
// - with bit set and pin low, run a full charge cycle autonomously.
// - start only with converter up, enabled, nonzero current, no faults, switch allowed.
// - reset defaults 4.208 V, 2.048 A, 128 mA, 256 mA, profile on, 12 h.
// - terminate when current low, voltage above recharge, no limiting or thermal regulation.
// - after done, restart when battery drops below the selected recharge threshold.
// - a toggle of enable pin or bit after done restarts the cycle.
// - status pin low charging, high done or disabled, blinking on fault; disable bit.
// - phase status 00 disabled, 01 precharge, 10 fast, 11 done.
// - on termination set phase done and pulse the host event.
// - pick short, precharge or fast current from battery voltage at start.
// - under limiting or thermal regulation hold termination, timer at half rate.
// - after termination switch battery off, converter runs, supplement may reconnect it.
// - termination enable bit low prevents termination.
// - voltage target raised by current times resistance, limited by clamp.
// - start only with thermistor in window; suspend outside, resume when back.
// - warm zone with warm select low lowers target by 200 mV.
// - cool zone reduces fast current to 20% or 50% by select bit.
// - boost suspended outside boost window; boost hot threshold 11 disables check.
// - safety timer expiry sets fault code 11 and pulses the host.
// - each host event is one 256 us pulse.
module battery_charge_cycle_controller
  import charge_cycle_pkg::*;
#(
  parameter int pulse_cycles = event_pulse_cycles,
  parameter int blink_cycles = blink_half_cycles
)(
  input  wire logic             clk,
  input  wire logic             rst_b,
  input  wire logic             converter_running,
  input  wire logic             charge_enable_bit,
  input  wire logic             charge_enable_pin_b,
  input  wire logic [12:0]      fast_charge_current_setting,
  input  wire logic [12:0]      charge_voltage_setting,
  input  wire logic [12:0]      precharge_current,
  input  wire logic [12:0]      termination_current,
  input  wire logic [12:0]      short_battery_current,
  input  wire logic             battery_switch_off_request,
  input  wire logic             recharge_offset_select,
  input  wire logic             termination_enable,
  input  wire logic             status_pin_disable,
  input  wire logic             warm_voltage_select,
  input  wire logic             cool_current_select,
  input  wire logic [1:0]       boost_hot_threshold,
  input  wire logic [1:0]       boost_cold_threshold,
  input  wire logic             boost_request,
  input  wire logic             safety_timer_expired,
  input  wire logic [12:0]      actual_charge_current,
  input  wire logic [7:0]       resistance_comp_setting,
  input  wire logic [12:0]      comp_voltage_clamp,
  input  wire analog_flags_type analog_flags_raw,
  output charge_state_type      charge_state,
  output logic [1:0]            charge_phase_status,
  output logic [1:0]            charge_fault_code,
  output logic [12:0]           charge_current_target,
  output logic [12:0]           charge_voltage_target,
  output logic                  battery_switch,
  output logic                  boost_active,
  output logic                  timer_half_rate,
  output logic                  status_pin_out,
  output logic                  status_pin_oe,
  output logic                  host_event_pulse,
  output logic [12:0]           reset_charge_voltage,
  output logic [12:0]           reset_fast_current,
  output logic [12:0]           reset_precharge_current,
  output logic [12:0]           reset_termination_current,
  output logic                  reset_temp_profile_en,
  output logic [4:0]            reset_safety_timer_hours
);
  // ****************************************
  // flag synchronisation
  // ****************************************
  localparam int flag_count = $bits(analog_flags_type);
  wire analog_flags_type flags;
  genvar gi;
  generate
    for (gi = 0; gi < flag_count; gi++) begin : g_sync
      flag_sync u_sync (
        .clk      (clk),
        .rst_b    (rst_b),
        .async_in (analog_flags_raw[gi]),
        .sync_out (flags[gi])
      );
    end
  endgenerate

  // ****************************************
  // defaults and qualification
  // ****************************************
  assign reset_charge_voltage      = default_charge_voltage_mv;
  assign reset_fast_current        = default_fast_current_ma;
  assign reset_precharge_current   = default_precharge_ma;
  assign reset_termination_current = default_termination_ma;
  assign reset_temp_profile_en     = default_temp_profile_en;
  assign reset_safety_timer_hours  = default_safety_timer_hours;
  logic enabled;
  logic start_ok;
  logic regulating;
  logic terminate;
  logic enable_prev;
  logic enable_rise;
  logic fault_pending;
  assign enabled    = charge_enable_bit && !charge_enable_pin_b;
  assign start_ok   = converter_running && enabled && (fast_charge_current_setting != 13'h0000) &&
                      flags.ts_in_charge_window && !fault_pending && !battery_switch_off_request;
  assign regulating = flags.power_limiting || flags.thermal_regulation;
  assign terminate  = termination_enable && flags.current_below_term &&
                      flags.bat_above_recharge && !regulating;
  // recharge comparator threshold is trimmed by the offset select in the analog front end
  // either the pin or the bit going from off to on counts as a restart
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      enable_prev <= 1'b0;
    end else begin
      enable_prev <= enabled;
    end
  end
  assign enable_rise = enabled && !enable_prev;

  // ****************************************
  // charge state machine
  // ****************************************
  charge_state_type next_charge_state;
  logic             next_is_fast;
  assign next_is_fast = !flags.bat_below_3v;
  always_comb begin
    next_charge_state = charge_state;
    case (charge_state)
      st_idle: begin
        if (start_ok) begin
          next_charge_state = next_is_fast ? st_fast : st_precharge;
        end
      end
      st_precharge, st_fast: begin
        if (!enabled || fault_pending || !converter_running) begin
          next_charge_state = st_idle;
        end else if (!flags.ts_in_charge_window) begin
          next_charge_state = st_suspend;
        end else if (terminate) begin
          next_charge_state = st_done;
        end else if (charge_state == st_precharge && next_is_fast) begin
          next_charge_state = st_fast;
        end
      end
      st_suspend: begin
        if (!enabled || fault_pending) begin
          next_charge_state = st_idle;
        end else if (flags.ts_in_charge_window) begin
          next_charge_state = next_is_fast ? st_fast : st_precharge;
        end
      end
      st_done: begin
        if (!enabled) begin
          next_charge_state = st_idle;
        end else if (!flags.bat_above_recharge && start_ok) begin
          next_charge_state = next_is_fast ? st_fast : st_precharge;
        end
      end
      default: next_charge_state = st_idle;
    endcase
  end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      charge_state <= st_idle;
    end else begin
      charge_state <= next_charge_state;
    end
  end
  logic charging;
  assign charging = (charge_state == st_precharge) || (charge_state == st_fast);

  always_comb begin
    case (charge_state)
      st_precharge: charge_phase_status = phase_precharge;
      st_fast:      charge_phase_status = phase_fast;
      st_done:      charge_phase_status = phase_done;
      st_suspend:   charge_phase_status = next_is_fast ? phase_fast : phase_precharge;
      default:      charge_phase_status = phase_disabled;
    endcase
  end

  // battery switch opens after termination; supplement may close it again
  assign battery_switch  = !battery_switch_off_request && (charge_state != st_done || !converter_running ||
                           !flags.bat_above_recharge);
  assign timer_half_rate = charging && regulating;

  // ****************************************
  // current and voltage targets
  // ****************************************
  function automatic logic [12:0] percent_of(input logic [12:0] value, input logic [6:0] pct);
    logic [19:0] product;
    product    = value * pct;
    percent_of = 13'(product / 20'd100);
  endfunction

  logic [12:0] next_current_target;
  logic [12:0] next_voltage_target;
  logic [20:0] comp_product;
  logic [12:0] comp_add;
  logic [13:0] comp_sum;

  always_comb begin
    next_current_target = 13'h0000;
    if (charging) begin
      if (flags.bat_below_2v) begin
        next_current_target = short_battery_current;
      end else if (flags.bat_below_3v) begin
        next_current_target = precharge_current;
      end else if (flags.ts_cool_zone) begin
        next_current_target = percent_of(fast_charge_current_setting,
                                         cool_current_select ? cool_high_percent : cool_low_percent);
      end else begin
        next_current_target = percent_of(fast_charge_current_setting, full_percent);
      end
    end
  end

  always_comb begin
    comp_product = actual_charge_current * resistance_comp_setting;
    comp_add     = (comp_product[20:13] != 8'h00 || comp_product[12:0] > comp_voltage_clamp) ?
                   comp_voltage_clamp : comp_product[12:0];
    comp_sum     = {1'b0, charge_voltage_setting} + {1'b0, comp_add};
    if (flags.ts_warm_zone && !warm_voltage_select) begin
      comp_sum = comp_sum - {1'b0, warm_voltage_drop_mv};
    end
    next_voltage_target = comp_sum[13] ? 13'h1fff : comp_sum[12:0];
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      charge_current_target <= 13'h0000;
      charge_voltage_target <= default_charge_voltage_mv;
    end else begin
      charge_current_target <= next_current_target;
      charge_voltage_target <= next_voltage_target;
    end
  end

  // ****************************************
  // boost thermal window
  // ****************************************
  // boost window thresholds are applied by the analog comparator feeding the window flag
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      boost_active <= 1'b0;
    end else begin
      boost_active <= boost_request &&
                      (boost_hot_threshold == boost_check_off || flags.ts_in_boost_window);
    end
  end

  // ****************************************
  // faults, events and status pin
  // ****************************************
  logic timer_prev;
  logic timer_rise;
  logic term_event;
  logic [$clog2(pulse_cycles+1)-1:0] pulse_count;
  logic [$clog2(blink_cycles+1)-1:0] blink_count;
  logic blink_level;

  assign timer_rise = safety_timer_expired && !timer_prev;
  assign term_event = charging && next_charge_state == st_done;
  assign fault_pending = charge_fault_code != fault_none;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      timer_prev        <= 1'b0;
      charge_fault_code <= fault_none;
    end else begin
      timer_prev <= safety_timer_expired;
      if (timer_rise) begin
        charge_fault_code <= fault_timer;
      end else if (enable_rise) begin
        charge_fault_code <= fault_none;
      end
    end
  end

  // one fixed-length pulse per event; events during a pulse merge into it
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pulse_count <= '0;
    end else if ((term_event || timer_rise) && pulse_count == '0) begin
      pulse_count <= ($bits(pulse_count))'(pulse_cycles);
    end else if (pulse_count != '0) begin
      pulse_count <= pulse_count - 1'b1;
    end
  end
  assign host_event_pulse = pulse_count != '0;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      blink_count <= '0;
      blink_level <= 1'b0;
    end else if (blink_count == '0) begin
      blink_count <= ($bits(blink_count))'(blink_cycles - 1);
      blink_level <= !blink_level;
    end else begin
      blink_count <= blink_count - 1'b1;
    end
  end

  logic status_fault;
  assign status_fault = fault_pending || charge_state == st_suspend ||
                        (boost_request && !boost_active);
  // open drain: enable high pulls the pin low
  assign status_pin_out = 1'b0;
  assign status_pin_oe  = !status_pin_disable &&
                          (status_fault ? blink_level : charging);
  // ****************************************
  // checks
  // ****************************************
  sequence pulse_held;
    host_event_pulse [*8];
  endsequence
  a_pulse_length: assert property (@(posedge clk) disable iff (!rst_b)
    $rose(host_event_pulse) |-> pulse_held) else $error("event pulse too short");
  a_done_phase: assert property (@(posedge clk) disable iff (!rst_b)
    term_event |=> charge_state == st_done && charge_phase_status == phase_done) else $error("done phase code");
  a_term_pulse: assert property (@(posedge clk) disable iff (!rst_b)
    term_event && !host_event_pulse |=> host_event_pulse) else $error("no pulse on termination");
  a_term_blocked: assert property (@(posedge clk) disable iff (!rst_b)
    charging && !termination_enable |=> charge_state != st_done) else $error("terminated while disabled");
  a_timer_fault: assert property (@(posedge clk) disable iff (!rst_b)
    timer_rise |=> charge_fault_code == fault_timer) else $error("timer fault code");
  a_start_qual: assert property (@(posedge clk) disable iff (!rst_b)
    charge_state == st_idle && !start_ok |=> charge_state == st_idle) else $error("start unqualified");
  a_half_rate: assert property (@(posedge clk) disable iff (!rst_b)
    charging && regulating |-> timer_half_rate ##1 charge_state != st_done) else $error("regulation handling");
  a_boost_window: assert property (@(posedge clk) disable iff (!rst_b)
    boost_active |-> $past(boost_request)) else $error("boost without request");
  a_status_pin: assert property (@(posedge clk) disable iff (!rst_b)
    status_pin_disable |-> !status_pin_oe) else $error("status pin driven when disabled");
endmodule

// [hw/charge_cycle_pkg.sv]
// shared constants and carrier types for the charge cycle controller
package charge_cycle_pkg;
  // default charge parameters, in mV / mA / hours
  localparam logic [12:0] default_charge_voltage_mv  = 13'd4208;
  localparam logic [12:0] default_fast_current_ma    = 13'd2048;
  localparam logic [12:0] default_precharge_ma       = 13'd128;
  localparam logic [12:0] default_termination_ma     = 13'd256;
  localparam logic        default_temp_profile_en    = 1'b1;
  localparam logic [4:0]  default_safety_timer_hours = 5'd12;
  localparam logic [12:0] warm_voltage_drop_mv       = 13'd200;
  localparam logic [6:0]  cool_low_percent           = 7'd20;
  localparam logic [6:0]  cool_high_percent          = 7'd50;
  localparam logic [6:0]  full_percent               = 7'd100;

  // charge phase status, fault and boost threshold codes
  localparam logic [1:0] phase_disabled = 2'b00;
  localparam logic [1:0] phase_precharge = 2'b01;
  localparam logic [1:0] phase_fast      = 2'b10;
  localparam logic [1:0] phase_done      = 2'b11;
  localparam logic [1:0] fault_timer     = 2'b11;
  localparam logic [1:0] fault_none      = 2'b00;
  localparam logic [1:0] boost_check_off = 2'b11;

  // timing
  localparam int clk_mhz          = 250;
  localparam int event_pulse_us   = 256;
  localparam int event_pulse_cycles = event_pulse_us * clk_mhz;
  localparam int blink_hz         = 1;
  localparam int blink_half_cycles = (clk_mhz * 1000000) / (2 * blink_hz);

  // comparator flags from the analog side, all active high
  typedef struct packed {
    logic bat_below_2v;
    logic bat_below_3v;
    logic bat_above_recharge;
    logic current_below_term;
    logic ts_in_charge_window;
    logic ts_cool_zone;
    logic ts_warm_zone;
    logic ts_in_boost_window;
    logic power_limiting;
    logic thermal_regulation;
  } analog_flags_type;

  typedef enum logic [2:0] {
    st_idle      = 3'b000,
    st_precharge = 3'b001,
    st_fast      = 3'b010,
    st_suspend   = 3'b011,
    st_done      = 3'b100
  } charge_state_type;
endpackage

// [hw/flag_sync.sv]
// three-stage synchroniser with agreement filter for one flag
`timescale 1ns/10ps
module flag_sync
  import charge_cycle_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst_b,
  input  wire logic async_in,
  output logic      sync_out
);
  logic stage1;
  logic stage2;
  logic stage3;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      stage1 <= 1'b0;
      stage2 <= 1'b0;
      stage3 <= 1'b0;
    end else begin
      stage1 <= async_in;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  // a change is accepted once the second and third stage agree
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sync_out <= 1'b0;
    end else if (stage2 == stage3) begin
      sync_out <= stage3;
    end
  end
endmodule

// [test/analog_side_model.sv]
// comparator and thermistor stand-in that feeds the controller's raw flags
`timescale 1ns/10ps
module analog_side_model
  import charge_cycle_pkg::*;
#(
  parameter int recharge_low_mv  = 100,
  parameter int recharge_high_mv = 200
)(
  input  wire logic [12:0] battery_mv,
  input  wire logic [12:0] actual_charge_current,
  input  wire logic [12:0] termination_current,
  input  wire logic [12:0] charge_voltage_setting,
  input  wire logic        recharge_offset_select,
  input  wire logic [2:0]  ts_zone,
  input  wire logic        power_limiting,
  output analog_flags_type analog_flags_raw
);
  // ts_zone: 0 too cold, 1 cool, 2 normal, 3 warm, 4 too hot
  logic [12:0] recharge_mv;
  assign recharge_mv = charge_voltage_setting - (recharge_offset_select ? 13'(recharge_high_mv)
                                                                        : 13'(recharge_low_mv));
  always_comb begin
    analog_flags_raw.bat_below_2v        = battery_mv < 13'h7d0;
    analog_flags_raw.bat_below_3v        = battery_mv < 13'hbb8;
    analog_flags_raw.bat_above_recharge  = battery_mv > recharge_mv;
    analog_flags_raw.current_below_term  = actual_charge_current < termination_current;
    analog_flags_raw.ts_in_charge_window = ts_zone != 3'h0 && ts_zone != 3'h4;
    analog_flags_raw.ts_cool_zone        = ts_zone == 3'h1;
    analog_flags_raw.ts_warm_zone        = ts_zone == 3'h3;
    analog_flags_raw.ts_in_boost_window  = ts_zone != 3'h0 && ts_zone != 3'h4;
    analog_flags_raw.power_limiting      = power_limiting;
    // die temperature stays low: thermal regulation is tied to 0 and never asserts
    analog_flags_raw.thermal_regulation  = 1'b0;
  end
endmodule

// [test/battery_charge_cycle_controller_tb.sv]
// self-checking bench for the charge cycle controller
`timescale 1ns/10ps
module battery_charge_cycle_controller_tb;
  import charge_cycle_pkg::*;
  logic clk, rst_b, converter_running, charge_enable_bit, charge_enable_pin_b, battery_switch_off_request;
  logic recharge_offset_select, termination_enable, status_pin_disable, warm_voltage_select;
  logic cool_current_select, boost_request, safety_timer_expired, power_limiting, reset_temp_profile_en;
  logic battery_switch, boost_active, timer_half_rate, status_pin_out, status_pin_oe, host_event_pulse;
  logic [12:0] fast_charge_current_setting, charge_voltage_setting, precharge_current, termination_current;
  logic [12:0] short_battery_current, actual_charge_current, comp_voltage_clamp, battery_mv;
  logic [12:0] charge_current_target, charge_voltage_target, reset_charge_voltage, reset_fast_current;
  logic [12:0] reset_precharge_current, reset_termination_current;
  logic [7:0]  resistance_comp_setting;
  logic [4:0]  reset_safety_timer_hours;
  logic [2:0]  ts_zone;
  logic [1:0]  boost_hot_threshold, boost_cold_threshold, charge_phase_status, charge_fault_code;
  analog_flags_type analog_flags_raw;
  charge_state_type charge_state;
  int          error_cnt = 0;
  int          n_compared = 0;

  battery_charge_cycle_controller #(.pulse_cycles(16), .blink_cycles(8)) i_battery_charge_cycle_controller (.*);
  analog_side_model i_analog_side_model (.*);

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // ****************************************
  // shared tasks
  // ****************************************
  task automatic check(input string what, input logic [12:0] exp, input logic [12:0] got);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic stop_test;
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic cycles(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // bounded wait; flags take several cycles to pass the synchronisers
  task automatic wait_state(input charge_state_type s);
    for (int k = 0; k < 40; k++) begin
      @(posedge clk);
      #1;
      if (charge_state === s) return;
    end
    error_cnt++;
    $display("[FAIL] state wait expected %0d seen %0d", s, charge_state);
    stop_test();
  endtask

  task automatic count_pulse(input int n, output int hi, output int edges);
    logic last;
    // stay clear of the edge that launches the pulse
    #1;
    hi = 0;
    edges = 0;
    last = status_pin_oe;
    for (int k = 0; k < n; k++) begin
      hi += (host_event_pulse === 1'b1);
      edges += (status_pin_oe !== last);
      last = status_pin_oe;
      cycles(1);
    end
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_defaults;
    check("vreg default", 13'h1070, reset_charge_voltage);
    check("fast_charge_current_setting default", 13'h800, reset_fast_current);
    check("ipre default", 13'h80, reset_precharge_current);
    check("iterm default", 13'h100, reset_termination_current);
    check("profile default", 13'h1, {12'h0, reset_temp_profile_en});
    check("timer default", 13'hc, {8'h0, reset_safety_timer_hours});
    check("phase idle", 13'h0, {11'h0, charge_phase_status});
    check("stat idle", 13'h0, {12'h0, status_pin_oe});
    check("stat pin level", 13'h0, {12'h0, status_pin_out});
  endtask

  task automatic t_no_start;
    @(posedge clk);
    fast_charge_current_setting <= 13'h0;
    charge_enable_bit <= 1'b1;
    cycles(30);
    check("zero fast_charge_current_setting phase", 13'h0, {11'h0, charge_phase_status});
    @(posedge clk);
    fast_charge_current_setting <= 13'h800;
    battery_switch_off_request <= 1'b1;
    cycles(30);
    check("switch off phase", 13'h0, {11'h0, charge_phase_status});
    @(posedge clk);
    battery_switch_off_request <= 1'b0;
    charge_enable_bit <= 1'b0;
  endtask

  task automatic t_phases;
    logic [12:0] bat[3] = '{13'h5dc, 13'h9c4, 13'he10};
    logic [12:0] cur[3] = '{13'h32, 13'h80, 13'h800};
    logic [1:0]  ph[3] = '{phase_precharge, phase_precharge, phase_fast};
    for (int i = 0; i < 3; i++) begin
      @(posedge clk);
      battery_mv <= bat[i];
      charge_enable_bit <= 1'b0;
      wait_state(st_idle);
      check("disabled phase", 13'h0, {11'h0, charge_phase_status});
      // battery flags lag the synchronisers; the start decision must see the new voltage
      cycles(6);
      @(posedge clk);
      // middle entry restarts through the pin instead of the bit
      if (i == 1) charge_enable_pin_b <= 1'b1;
      charge_enable_bit <= 1'b1;
      if (i == 1) repeat (5) @(posedge clk);
      if (i == 1) charge_enable_pin_b <= 1'b0;
      wait_state(ph[i] == phase_fast ? st_fast : st_precharge);
      cycles(2);
      check("start phase", {11'h0, ph[i]}, {11'h0, charge_phase_status});
      check("start current", cur[i], charge_current_target);
    end
    check("stat charging", 13'h1, {12'h0, status_pin_oe});
    check("comp target", 13'h10d4, charge_voltage_target);
    @(posedge clk);
    status_pin_disable <= 1'b1;
    fast_charge_current_setting <= 13'h3e8;
    ts_zone <= 3'h1;
    cycles(10);
    check("stat disabled", 13'h0, {12'h0, status_pin_oe});
    check("cool 20", 13'hc8, charge_current_target);
    @(posedge clk);
    status_pin_disable <= 1'b0;
    cool_current_select <= 1'b1;
    cycles(10);
    check("cool 50", 13'h1f4, charge_current_target);
    @(posedge clk);
    resistance_comp_setting <= 8'h0;
    ts_zone <= 3'h3;
    cycles(10);
    check("warm target", 13'hfa8, charge_voltage_target);
    @(posedge clk);
    ts_zone <= 3'h2;
    fast_charge_current_setting <= 13'h800;
  endtask

  task automatic t_terminate;
    int hi, ed;
    @(posedge clk);
    battery_mv <= 13'h1068;
    actual_charge_current <= 13'h64;
    termination_enable <= 1'b0;
    cycles(30);
    check("no term phase", {11'h0, phase_fast}, {11'h0, charge_phase_status});
    // limiting goes through the synchronisers, so it must settle before termination is allowed
    @(posedge clk);
    power_limiting <= 1'b1;
    cycles(6);
    @(posedge clk);
    termination_enable <= 1'b1;
    cycles(30);
    check("limit phase", {11'h0, phase_fast}, {11'h0, charge_phase_status});
    check("half rate", 13'h1, {12'h0, timer_half_rate});
    @(posedge clk);
    power_limiting <= 1'b0;
    wait_state(st_done);
    count_pulse(40, hi, ed);
    check("done phase", {11'h0, phase_done}, {11'h0, charge_phase_status});
    check("done pulse", 13'd16, 13'(hi));
    check("done switch", 13'h0, {12'h0, battery_switch});
    check("stat done", 13'h0, {12'h0, status_pin_oe});
    @(posedge clk);
    actual_charge_current <= 13'h800;
    battery_mv <= 13'hf3c;
    wait_state(st_fast);
  endtask

  task automatic t_faults;
    int hi, ed;
    @(posedge clk);
    ts_zone <= 3'h0;
    wait_state(st_suspend);
    count_pulse(40, hi, ed);
    check("ts blink", 13'h1, {12'h0, ed >= 2});
    @(posedge clk);
    ts_zone <= 3'h2;
    wait_state(st_fast);
    @(posedge clk);
    safety_timer_expired <= 1'b1;
    count_pulse(40, hi, ed);
    check("timer fault", {11'h0, fault_timer}, {11'h0, charge_fault_code});
    check("fault pulse", 13'd16, 13'(hi));
    @(posedge clk);
    boost_request <= 1'b1;
    charge_enable_bit <= 1'b0;
    cycles(20);
    check("boost in", 13'h1, {12'h0, boost_active});
    @(posedge clk);
    ts_zone <= 3'h4;
    cycles(20);
    check("boost out", 13'h0, {12'h0, boost_active});
    @(posedge clk);
    boost_hot_threshold <= boost_check_off;
    cycles(20);
    check("boost check off", 13'h1, {12'h0, boost_active});
  endtask

  initial begin
    rst_b = 1'b0;
    converter_running = 1'b1;
    charge_enable_bit = 1'b0;
    charge_enable_pin_b = 1'b0;
    battery_switch_off_request = 1'b0;
    recharge_offset_select = 1'b0;
    termination_enable = 1'b1;
    status_pin_disable = 1'b0;
    warm_voltage_select = 1'b0;
    cool_current_select = 1'b0;
    boost_request = 1'b0;
    safety_timer_expired = 1'b0;
    power_limiting = 1'b0;
    fast_charge_current_setting = 13'h800;
    charge_voltage_setting = 13'h1070;
    precharge_current = 13'h80;
    termination_current = 13'h100;
    short_battery_current = 13'h32;
    actual_charge_current = 13'h800;
    // clamp and resistance programmed before compensation is relied on
    comp_voltage_clamp = 13'h64;
    resistance_comp_setting = 8'h1;
    battery_mv = 13'he10;
    ts_zone = 3'h2;
    boost_hot_threshold = 2'b00;
    boost_cold_threshold = 2'b00;
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    cycles(8);
    t_defaults();
    t_no_start();
    t_phases();
    t_terminate();
    t_faults();
    stop_test();
  end
endmodule
